/* File: ccs_pkg.sv */
// Constants shared by the core control block and its return stack.
// Assumes one 10 MHz clock and an active-low asynchronous reset.
package ccs_pkg;

	// Program counter and return stack geometry
	localparam int          PC_W        = 15;
	localparam int          STACK_DEPTH = 16;
	localparam logic [14:0] RESET_VEC   = 15'h0000;
	localparam logic [14:0] INT_VEC     = 15'h0004;

	// Indirect pointer layout
	localparam int PTR_W       = 16;
	localparam int PROG_SEL_BIT = 15;  // High byte bit 7
	localparam int LINEAR_BIT  = 13;   // Selects the linear GPR view
	localparam int DADDR_W     = 12;
	localparam int PADDR_W     = 15;
	localparam int PDATA_W     = 14;

	// Linear view: 80 GPR bytes per bank after 12 core and 20 SFR bytes
	localparam logic [12:0] GPR_PER_BANK = 13'h0050;
	localparam logic [12:0] GPR_BASE     = 13'h0020;

	// Instruction set size
	localparam logic [5:0] NUM_INSTR = 6'h31;

	// Indirect access sequencer
	typedef enum logic [1:0] {
		IND_IDLE,
		IND_DREAD,
		IND_PFETCH,
		IND_PWAIT
	} ccs_ind_e;

endpackage : ccs_pkg

/* File: ccs_ret_stack.sv */
// Hardware return-address stack with overflow and underflow detection.
// Assumes push and pop are one-cycle strobes and never both high.
`timescale 1ns/100ps

module ccs_ret_stack #(
	parameter int DEPTH = ccs_pkg::STACK_DEPTH,
	parameter int WIDTH = ccs_pkg::PC_W
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             flush_i,
	input  wire logic             push_i,
	input  wire logic             pop_i,
	input  wire logic [WIDTH-1:0] push_data_i,
	output logic      [WIDTH-1:0] top_o,
	output logic                  overflow_o,
	output logic                  underflow_o
);

	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int IDX_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_m1;
	wire              full  = (cnt_q == CNT_W'(DEPTH));
	wire              empty = (cnt_q == '0);

	// Fault detection; a full push or empty pop leaves the stack as it is
	assign overflow_o  = push_i & full;   // [RL13]
	assign underflow_o = pop_i & empty;   // [RL13]
	assign cnt_m1      = cnt_q - CNT_W'(1);
	assign top_o       = empty ? '0 : mem_q[cnt_m1[IDX_W-1:0]];

	// Storage kept apart from data memory, no reset needed on the array
	always_ff @(posedge clk_i) begin
		if (push_i && !full && !flush_i) begin
			mem_q[cnt_q[IDX_W-1:0]] <= push_data_i;  // [RL1]
		end
	end

	// Occupancy count
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= '0;
		end else if (flush_i) begin
			cnt_q <= '0;
		end else if (push_i && !full) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end else if (pop_i && !empty) begin
			cnt_q <= cnt_m1;
		end
	end

endmodule : ccs_ret_stack

/* File: ccs_core_ctrl.sv */
// Core control: program counter, return stack, stack faults, interrupt
// context shadows, two indirect pointers and the indirect access sequencer.
// Assumes a decoder upstream gives one-cycle operation strobes, data memory
// reads asynchronously and program memory answers one cycle after a read.
`timescale 1ns/100ps

// Operation
// [RL1] Sixteen-entry, 15-bit return stack, separate storage
// [RL2] Sticky overflow and underflow flags
// [RL3] Optional stack-fault soft reset
// [RL4] Shadow context saved and restored on interrupts
// [RL5] Two 16-bit pointers reach data and program
// [RL6] Program memory indirect read takes extra cycle
// [RL7] Linear GPR view across bank boundaries
// [RL8] Instruction index limited to 49 entries
// [RL9] Direct, indirect and relative addressing supported
// [RL10] 15-bit PC, reset 0000h, interrupt 0004h
// [RL11] Bit 7 of high byte selects program
// [RL12] Indirect writes to program memory ignored
// [RL13] Overflow on full push, underflow empty pop
module ccs_core_ctrl #(
	parameter int CTX_W = 32
) (
	input  wire logic                        clk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        stk_fault_reset_en_i,
	input  wire logic                        instr_valid_i,
	input  wire logic [5:0]                  instr_idx_i,
	input  wire logic                        pc_inc_i,
	input  wire logic                        jump_i,
	input  wire logic                        branch_i,
	input  wire logic [ccs_pkg::PC_W-1:0]    target_i,
	input  wire logic                        call_i,
	input  wire logic                        ret_i,
	input  wire logic                        int_enter_i,
	input  wire logic                        int_return_i,
	input  wire logic [CTX_W-1:0]            ctx_i,
	input  wire logic                        ovf_clr_i,
	input  wire logic                        unf_clr_i,
	input  wire logic                        ptr_wr_i,
	input  wire logic                        ptr_sel_i,
	input  wire logic                        ptr_byte_hi_i,
	input  wire logic [7:0]                  ptr_wr_data_i,
	input  wire logic                        ind_rd_i,
	input  wire logic                        ind_wr_i,
	input  wire logic                        ind_sel_i,
	input  wire logic [7:0]                  ind_wr_data_i,
	input  wire logic [7:0]                  dmem_rdata_i,
	input  wire logic [ccs_pkg::PDATA_W-1:0] pmem_rdata_i,
	output logic      [ccs_pkg::PC_W-1:0]    pc_o,
	output logic                             stack_overflow_flag_o,
	output logic                             stack_underflow_flag_o,
	output logic                             soft_reset_o,
	output logic                             illegal_instr_o,
	output logic      [CTX_W-1:0]            ctx_restore_o,
	output logic                             ctx_restore_valid_o,
	output logic      [ccs_pkg::PTR_W-1:0]   ptr0_o,
	output logic      [ccs_pkg::PTR_W-1:0]   ptr1_o,
	output logic      [ccs_pkg::DADDR_W-1:0] dmem_addr_o,
	output logic                             dmem_re_o,
	output logic                             dmem_we_o,
	output logic      [7:0]                  dmem_wdata_o,
	output logic      [ccs_pkg::PADDR_W-1:0] pmem_addr_o,
	output logic                             pmem_re_o,
	output logic      [7:0]                  ind_rdata_o,
	output logic                             ind_done_o,
	output logic                             ind_busy_o
);

	logic [ccs_pkg::PC_W-1:0]    pc_q, pc_d;
	logic                        ovf_q, unf_q, srst_q, ill_q;
	logic [CTX_W-1:0]            shadow_q, restore_q;
	logic                        restore_vld_q;
	logic [ccs_pkg::PTR_W-1:0]   ptr0_q, ptr1_q;
	ccs_pkg::ccs_ind_e           st_q, st_d;
	logic [ccs_pkg::DADDR_W-1:0] daddr_q, daddr_d;
	logic [ccs_pkg::PADDR_W-1:0] paddr_q, paddr_d;
	logic                        dre_q, dre_d, dwe_q, dwe_d, pre_q, pre_d;
	logic [7:0]                  dwd_q, dwd_d, rdat_q, rdat_d;
	logic                        done_q, done_d, busy_q, busy_d;
	logic [ccs_pkg::PC_W-1:0]    stk_top;
	logic                        stk_ovf, stk_unf;

	// Stack strobes; a fault reset in flight blocks further stack traffic
	wire stk_push = ~srst_q & (int_enter_i | call_i);
	wire stk_pop  = ~srst_q & ~stk_push & (ret_i | int_return_i);
	wire [ccs_pkg::PC_W-1:0] push_pc = int_enter_i ? pc_q :
	                                   pc_q + ccs_pkg::PC_W'(1);
	wire stk_fault = stk_ovf | stk_unf;

	ccs_ret_stack #(
		.DEPTH (ccs_pkg::STACK_DEPTH),
		.WIDTH (ccs_pkg::PC_W)
	) u_stack (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (srst_q),
		.push_i      (stk_push),
		.pop_i       (stk_pop),
		.push_data_i (push_pc),
		.top_o       (stk_top),
		.overflow_o  (stk_ovf),
		.underflow_o (stk_unf)
	);

	// Pointer decode: program, linear GPR or banked (traditional) address
	wire [ccs_pkg::PTR_W-1:0] sel_ptr = ind_sel_i ? ptr1_q : ptr0_q;
	wire        to_prog  = sel_ptr[ccs_pkg::PROG_SEL_BIT];  // [RL11]
	wire        to_lin   = sel_ptr[ccs_pkg::LINEAR_BIT];
	wire [12:0] lin_off  = sel_ptr[12:0];
	wire [12:0] lin_bank = lin_off / ccs_pkg::GPR_PER_BANK;           // [RL7]
	wire [12:0] lin_rem  = lin_off % ccs_pkg::GPR_PER_BANK;           // [RL7]
	wire [12:0] lin_pos  = lin_rem + ccs_pkg::GPR_BASE;
	wire [ccs_pkg::DADDR_W-1:0] lin_addr = {lin_bank[4:0], lin_pos[6:0]};
	wire [ccs_pkg::DADDR_W-1:0] data_addr = to_lin ? lin_addr :
	                                        sel_ptr[ccs_pkg::DADDR_W-1:0];

	// Program counter next value; fault reset outranks every other source
	always_comb begin
		pc_d = pc_q;
		if (srst_q) begin
			pc_d = ccs_pkg::RESET_VEC;                  // [RL3]
		end else if (int_enter_i) begin
			pc_d = ccs_pkg::INT_VEC;                    // [RL10]
		end else if (call_i || jump_i) begin
			pc_d = target_i;
		end else if (ret_i || int_return_i) begin
			pc_d = stk_top;
		end else if (branch_i) begin
			pc_d = pc_q + target_i;                     // [RL9]
		end else if (pc_inc_i) begin
			pc_d = pc_q + ccs_pkg::PC_W'(1);
		end
	end

	// PC, stack flags and fault reset; a new fault beats a clear
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_q   <= ccs_pkg::RESET_VEC;                  // [RL10]
			ovf_q  <= 1'b0;
			unf_q  <= 1'b0;
			srst_q <= 1'b0;
		end else begin
			pc_q   <= pc_d;
			ovf_q  <= stk_ovf | (ovf_q & ~ovf_clr_i);      // [RL2]
			unf_q  <= stk_unf | (unf_q & ~unf_clr_i);      // [RL2]
			srst_q <= stk_fault & stk_fault_reset_en_i;    // [RL3]
		end
	end

	// Instruction index check and interrupt context shadows
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ill_q         <= 1'b0;
			shadow_q      <= '0;
			restore_q     <= '0;
			restore_vld_q <= 1'b0;
		end else begin
			ill_q <= instr_valid_i & (instr_idx_i >= ccs_pkg::NUM_INSTR); // [RL8]
			if (int_enter_i) begin
				shadow_q <= ctx_i;                         // [RL4]
			end
			if (int_return_i) begin
				restore_q <= shadow_q;                     // [RL4]
			end
			restore_vld_q <= int_return_i & ~srst_q;
		end
	end

	// Pointer byte writes; the fault reset clears both pointers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ptr0_q <= '0;
			ptr1_q <= '0;
		end else if (srst_q) begin
			ptr0_q <= '0;
			ptr1_q <= '0;
		end else if (ptr_wr_i && !ptr_sel_i) begin
			if (ptr_byte_hi_i) ptr0_q[15:8] <= ptr_wr_data_i;  // [RL5]
			else ptr0_q[7:0] <= ptr_wr_data_i;
		end else if (ptr_wr_i && ptr_sel_i) begin
			if (ptr_byte_hi_i) ptr1_q[15:8] <= ptr_wr_data_i;  // [RL5]
			else ptr1_q[7:0] <= ptr_wr_data_i;
		end
	end

	// Indirect sequencer; requests outside IDLE are not taken
	always_comb begin
		st_d    = st_q;
		daddr_d = daddr_q;
		paddr_d = paddr_q;
		dwd_d   = dwd_q;
		rdat_d  = rdat_q;
		dre_d   = 1'b0;
		dwe_d   = 1'b0;
		pre_d   = 1'b0;
		done_d  = 1'b0;
		busy_d  = busy_q;
		unique case (st_q)
			ccs_pkg::IND_IDLE: begin
				if (ind_rd_i && to_prog) begin
					paddr_d = sel_ptr[ccs_pkg::PADDR_W-1:0];  // [RL5]
					pre_d   = 1'b1;
					busy_d  = 1'b1;
					st_d    = ccs_pkg::IND_PFETCH;
				end else if (ind_rd_i) begin
					daddr_d = data_addr;                     // [RL5]
					dre_d   = 1'b1;
					busy_d  = 1'b1;
					st_d    = ccs_pkg::IND_DREAD;
				end else if (ind_wr_i && to_prog) begin
					done_d  = 1'b1;                          // [RL12]
				end else if (ind_wr_i) begin
					daddr_d = data_addr;
					dwd_d   = ind_wr_data_i;
					dwe_d   = 1'b1;
					done_d  = 1'b1;
				end
			end
			ccs_pkg::IND_DREAD: begin
				rdat_d = dmem_rdata_i;
				done_d = 1'b1;
				busy_d = 1'b0;
				st_d   = ccs_pkg::IND_IDLE;
			end
			ccs_pkg::IND_PFETCH: begin
				st_d = ccs_pkg::IND_PWAIT;                   // [RL6]
			end
			ccs_pkg::IND_PWAIT: begin
				rdat_d = pmem_rdata_i[7:0];                  // [RL11]
				done_d = 1'b1;
				busy_d = 1'b0;
				st_d   = ccs_pkg::IND_IDLE;
			end
		endcase
		if (srst_q) begin
			st_d   = ccs_pkg::IND_IDLE;
			busy_d = 1'b0;
			done_d = 1'b0;
			dre_d  = 1'b0;
			dwe_d  = 1'b0;
			pre_d  = 1'b0;
		end
	end

	// Sequencer registers drive the memory ports directly
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q    <= ccs_pkg::IND_IDLE;
			daddr_q <= '0;
			paddr_q <= '0;
			dwd_q   <= '0;
			rdat_q  <= '0;
			dre_q   <= 1'b0;
			dwe_q   <= 1'b0;
			pre_q   <= 1'b0;
			done_q  <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			daddr_q <= daddr_d;
			paddr_q <= paddr_d;
			dwd_q   <= dwd_d;
			rdat_q  <= rdat_d;
			dre_q   <= dre_d;
			dwe_q   <= dwe_d;
			pre_q   <= pre_d;
			done_q  <= done_d;
			busy_q  <= busy_d;
		end
	end

	// Outputs straight from flip-flops
	assign pc_o                   = pc_q;
	assign stack_overflow_flag_o  = ovf_q;
	assign stack_underflow_flag_o = unf_q;
	assign soft_reset_o           = srst_q;
	assign illegal_instr_o        = ill_q;
	assign ctx_restore_o          = restore_q;
	assign ctx_restore_valid_o    = restore_vld_q;
	assign ptr0_o                 = ptr0_q;
	assign ptr1_o                 = ptr1_q;
	assign dmem_addr_o            = daddr_q;
	assign dmem_re_o              = dre_q;
	assign dmem_we_o              = dwe_q;
	assign dmem_wdata_o           = dwd_q;
	assign pmem_addr_o            = paddr_q;
	assign pmem_re_o              = pre_q;
	assign ind_rdata_o            = rdat_q;
	assign ind_done_o             = done_q;
	assign ind_busy_o             = busy_q;

endmodule : ccs_core_ctrl

/* File: ccs_core_ctrl_chk.sv */
// Checker for the core control block: pc, stack faults, indirect timing.
// Assumes it is bound into ccs_core_ctrl; one clock, active-low reset.
`timescale 1ns/100ps
module ccs_core_ctrl_chk (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        stk_fault_reset_en_i,
	input wire logic        instr_valid_i,
	input wire logic [5:0]  instr_idx_i,
	input wire logic [14:0] target_i,
	input wire logic        call_i,
	input wire logic        int_enter_i,
	input wire logic        int_return_i,
	input wire logic        ovf_clr_i,
	input wire logic        ind_rd_i,
	input wire logic        ind_wr_i,
	input wire logic        ind_sel_i,
	input wire logic [14:0] pc_o,
	input wire logic        stack_overflow_flag_o,
	input wire logic        stack_underflow_flag_o,
	input wire logic        soft_reset_o,
	input wire logic        illegal_instr_o,
	input wire logic        ctx_restore_valid_o,
	input wire logic [15:0] ptr0_o,
	input wire logic [15:0] ptr1_o,
	input wire logic        dmem_we_o,
	input wire logic        dmem_re_o,
	input wire logic        pmem_re_o,
	input wire logic        ind_done_o,
	input wire logic        ind_busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Request qualifiers; a soft reset cycle drops requests, so skip it
	wire logic prog_sel = ind_sel_i ? ptr1_o[15] : ptr0_o[15];
	wire logic idle_req = !ind_busy_o && !soft_reset_o;

	// Data read answers after two edges, program read after three
	sequence data_rd_s;
		dmem_re_o && ind_busy_o ##1 ind_done_o && !ind_busy_o;
	endsequence
	sequence prog_rd_s;
		pmem_re_o && ind_busy_o ##1 !ind_done_o ##1 ind_done_o && !ind_busy_o;
	endsequence

	call_pc_a: assert property (call_i && !int_enter_i && !soft_reset_o
		|=> pc_o == $past(target_i)) else $error("call target not loaded");
	int_vec_a: assert property (int_enter_i && !soft_reset_o
		|=> pc_o == 15'h0004) else $error("interrupt vector wrong");
	ctx_rest_a: assert property (ctx_restore_valid_o
		|-> $past(int_return_i)) else $error("context restore unprompted");
	fault_rst_a: assert property (soft_reset_o |-> $past(stk_fault_reset_en_i)
		&& (stack_overflow_flag_o || stack_underflow_flag_o))
		else $error("soft reset without fault");
	rst_pc_a: assert property (soft_reset_o
		|=> pc_o == 15'h0000 && ptr0_o == 16'h0000) else $error("soft reset lost");
	flag_hold_a: assert property (stack_overflow_flag_o && !ovf_clr_i
		|=> stack_overflow_flag_o) else $error("overflow flag dropped");
	data_rd_a: assert property (ind_rd_i && idle_req && !prog_sel
		|=> data_rd_s) else $error("data read timing");
	prog_rd_a: assert property (ind_rd_i && idle_req && prog_sel
		|=> prog_rd_s) else $error("program read timing");
	prog_wr_a: assert property (
		ind_wr_i && !ind_rd_i && idle_req && prog_sel
		|=> ind_done_o && !dmem_we_o) else $error("program write not ignored");
	illegal_a: assert property (instr_valid_i
		|=> illegal_instr_o == ($past(instr_idx_i) >= 6'h31))
		else $error("instruction range check");
endmodule : ccs_core_ctrl_chk

bind ccs_core_ctrl ccs_core_ctrl_chk u_chk (.clk_i, .reset_n_i,
	.stk_fault_reset_en_i, .instr_valid_i, .instr_idx_i, .target_i, .call_i,
	.int_enter_i, .int_return_i, .ovf_clr_i, .ind_rd_i, .ind_wr_i, .ind_sel_i,
	.pc_o, .stack_overflow_flag_o, .stack_underflow_flag_o, .soft_reset_o,
	.illegal_instr_o, .ctx_restore_valid_o, .ptr0_o, .ptr1_o, .dmem_we_o,
	.dmem_re_o, .pmem_re_o, .ind_done_o, .ind_busy_o);

/* File: cpu_core_stack_and_pointers_tb.sv */
// Self-checking bench for ccs_core_ctrl with seeded random stimulus.
// Assumes the bound checker; inputs change 10 ns after each rising edge.
`timescale 1ns/100ps
module cpu_core_stack_and_pointers_tb;
	logic clk = 0, rst_n = 0, fen = 0, iv = 0, inc = 0, jmp = 0, br = 0;
	logic call = 0, ret = 0, ie = 0, ir = 0, oc = 0, uc = 0, pw = 0, ps = 0;
	logic ph = 0, rd = 0, wr = 0, is = 0;
	// Strobes as the design sees them, written once per cycle by cyc
	logic [12:0] stb = '0;
	logic [5:0]  idx = '0;
	logic [14:0] tgt = '0, pc, pa, pcx;
	logic [31:0] ctx = '0, cro, c;
	logic [7:0]  pd = '0, wd = '0, dr = '0, dwd, ird;
	logic [13:0] pr = '0;
	logic [15:0] p0, p1;
	logic [11:0] da;
	logic ovf, unf, srst, ill, crv, re, we, pre, done, busy;
	logic [14:0] stk[$];
	int n_fail = 0, samples_checked = 0, cycles = 0, seed = 32'h0722;

	ccs_core_ctrl u_ccs_core_ctrl (.clk_i(clk), .reset_n_i(rst_n),
		.stk_fault_reset_en_i(fen), .instr_valid_i(stb[12]),
		.instr_idx_i(idx), .pc_inc_i(stb[11]), .jump_i(stb[10]),
		.branch_i(stb[9]), .target_i(tgt), .call_i(stb[8]),
		.ret_i(stb[7]), .int_enter_i(stb[6]), .int_return_i(stb[5]),
		.ctx_i(ctx), .ovf_clr_i(stb[4]), .unf_clr_i(stb[3]),
		.ptr_wr_i(stb[2]), .ptr_sel_i(ps), .ptr_byte_hi_i(ph),
		.ptr_wr_data_i(pd), .ind_rd_i(stb[1]), .ind_wr_i(stb[0]),
		.ind_sel_i(is), .ind_wr_data_i(wd), .dmem_rdata_i(dr),
		.pmem_rdata_i(pr), .pc_o(pc), .stack_overflow_flag_o(ovf),
		.stack_underflow_flag_o(unf), .soft_reset_o(srst),
		.illegal_instr_o(ill), .ctx_restore_o(cro), .ctx_restore_valid_o(crv),
		.ptr0_o(p0), .ptr1_o(p1), .dmem_addr_o(da), .dmem_re_o(re),
		.dmem_we_o(we), .dmem_wdata_o(dwd), .pmem_addr_o(pa), .pmem_re_o(pre),
		.ind_rdata_o(ird), .ind_done_o(done), .ind_busy_o(busy));

	// Clock at 10 MHz
	initial begin
		forever #50 clk = ~clk;
	end

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report

	// Hang guard, well above the 126 or so cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			final_report();
		end
	end

	// Wide enough for a 32-bit context plus its valid bit
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Apply this cycle's strobes in one write, then let the edge pass;
	// a strobe is never lowered and raised again in the same time step
	task automatic cyc();
		stb = {iv, inc, jmp, br, call, ret, ie, ir, oc, uc, pw, rd, wr};
		{iv, inc, jmp, br, call, ret, ie, ir, oc, uc, pw, rd, wr} = '0;
		@(posedge clk);
		#10;
	endtask : cyc

	task automatic do_call(input logic [14:0] t);
		tgt = t;
		call = 1;
		cyc();
		stk.push_back(pcx + 15'h0001);
		pcx = t;
		chk(pc, pcx);
	endtask : do_call

	// Pop by return or interrupt return; an empty pop yields 0000h
	task automatic do_ret(input logic from_int);
		if (from_int) ir = 1;
		else ret = 1;
		cyc();
		pcx = stk.size() ? stk.pop_back() : 15'h0000;
		chk(pc, pcx);
	endtask : do_ret

	// Linear view: 80 bytes per bank, placed after the 32 low addresses
	function automatic logic [11:0] ea(input logic [15:0] v);
		logic [12:0] off;
		off = v[12:0];
		return v[13] ? {5'(off / 80), 7'(off % 80 + 32)} : v[11:0];
	endfunction : ea

	// Load a pointer byte by byte, then read and write through it
	task automatic access(input logic s, input logic [15:0] v);
		{ps, ph, pd, pw} = {s, 1'b1, v[15:8], 1'b1};
		cyc();
		{ps, ph, pd, pw} = {s, 1'b0, v[7:0], 1'b1};
		cyc();
		chk(s ? p1 : p0, v);
		{is, rd, dr, pr} = {s, 1'b1, 8'($random(seed)), 14'($random(seed))};
		cyc();
		if (v[15]) begin
			chk({pre, pa}, {1'b1, v[14:0]});
			cyc();
			chk(done, 0);
		end else chk({re, da, busy}, {1'b1, ea(v), 1'b1});
		cyc();
		chk({done, ird}, {1'b1, v[15] ? pr[7:0] : dr});
		{wr, wd} = {1'b1, 8'($random(seed))};
		cyc();
		chk({we, done}, {!v[15], 1'b1});
		if (!v[15]) chk({da, dwd}, {ea(v), wd});
	endtask : access

	initial begin
		pcx = '0;
		repeat (8) @(posedge clk);
		#10 rst_n = 1;
		chk({pc, ovf, unf}, 0);
		// Fill all 16 entries, then overflow with a 17th call
		for (int i = 0; i < 16; i++) do_call(15'($random(seed)));
		call = 1;
		cyc();
		chk({ovf, srst}, 2'b10);
		{jmp, tgt} = {1'b1, 15'h7ffe};
		cyc();
		pcx = 15'h7ffe;
		chk(pc, pcx);
		for (int i = 0; i < 17; i++) do_ret(0);
		chk({ovf, unf}, 2'b11);
		{oc, uc} = 2'b11;
		cyc();
		chk({ovf, unf}, 0);
		// Relative branches wrap within 15 bits
		for (int i = 0; i < 4; i++) begin
			{br, tgt} = {1'b1, 15'($random(seed))};
			cyc();
			pcx = pcx + tgt;
			chk(pc, pcx);
		end
		// Interrupt entry saves context, return restores it
		c = $random(seed);
		{ie, ctx} = {1'b1, c};
		cyc();
		stk.push_back(pcx);
		pcx = 15'h0004;
		chk(pc, pcx);
		inc = 1;
		cyc();
		do_ret(1);
		chk({crv, cro}, {1'b1, c});
		// Stack fault with the reset option on; a clear in the same
		// cycle as the fault must lose to it
		fen = 1;
		for (int i = 0; i < 16; i++) do_call(15'($random(seed)));
		{call, oc} = 2'b11;
		cyc();
		chk({ovf, srst}, 2'b11);
		cyc();
		fen = 0;
		stk.delete();
		chk({pc, ovf}, 1);
		pcx = '0;
		do_ret(0);
		chk(unf, 1);
		// Direct, linear across bank edges, and program pointers
		access(0, 16'h0a53);
		access(1, 16'h2000 | 16'd79);
		access(0, 16'h2000 | 16'd80);
		access(1, 16'h2000 | 16'(unsigned'($random(seed)) % 2560));
		access(1, 16'h8000 | 16'($random(seed)));
		access(0, 16'hffff);
		// Instruction index range, boundary values then random
		for (int i = 0; i < 24; i++) begin
			{iv, idx} = {1'b1, i < 6 ? 6'(46 + i) : 6'($random(seed))};
			cyc();
			chk(ill, idx >= 6'h31);
		end
		final_report();
	end
endmodule : cpu_core_stack_and_pointers_tb
